// ### lcd_port_pkg.sv
// constants, encodings and timing for the lcd host port and display ram
package lcd_port_pkg;
	// clock and timing
	localparam int CLK_NS = 8;
	localparam int PROC_NS = 24;
	localparam int PROC_CYCLES = (PROC_NS + CLK_NS - 1) / CLK_NS;
	localparam int OSC_NS = 4000;
	localparam int OSC_CYCLES = OSC_NS / CLK_NS;
	localparam int OSC_W = $clog2(OSC_CYCLES);
	localparam int WAIT_W = $clog2(PROC_CYCLES + 1);

	// ram geometry
	localparam int PAGES = 9;
	localparam int COLS = 132;
	localparam int BYTES = PAGES * COLS;
	localparam logic [10:0] COLS_IDX = 11'h084;
	localparam logic [3:0] IND_PAGE = 4'h8;
	localparam logic [7:0] IND_MASK = 8'h01;
	localparam logic [7:0] COL_LAST = 8'h83;
	localparam logic [6:0] ROW_COUNT = 7'h41;
	localparam logic [6:0] LINE_LAST = 7'h40;
	localparam logic [2:0] BIT_LAST = 3'h7;

	// fifo
	localparam int FIFO_DEPTH = 4;
	localparam int ENTRY_W = 10;

	typedef enum logic [1:0] {
		OP_CMD = 2'b00,
		OP_WDATA = 2'b01,
		OP_RDATA = 2'b10
	} op_t;

	// command byte layout
	localparam logic [3:0] CMD_MODE = 4'h0;
	localparam logic [3:0] CMD_PAGE = 4'h1;
	localparam logic [3:0] CMD_COL_HI = 4'h2;
	localparam logic [3:0] CMD_COL_LO = 4'h3;
	localparam logic [1:0] CMD_START_TAG = 2'h1;
	localparam int MODE_ON_BIT = 0;
	localparam int MODE_SEGREV_BIT = 1;
	localparam int MODE_REV_BIT = 2;
	localparam int MODE_ALL_BIT = 3;

	// status byte layout
	localparam int STAT_BUSY_BIT = 7;
	localparam int STAT_SEGREV_BIT = 6;
	localparam int STAT_OFF_BIT = 5;
endpackage

// ### lcd_host_port.sv
// host port, command fifo, display ram and refresh latch of the lcd driver
`timescale 1ns/1ns

module cmd_fifo #(
	parameter int WIDTH = 10,
	parameter int DEPTH = 4
) (
	input wire logic clock, // system clock
	input wire logic resetn, // synchronous reset, active low
	input wire logic in_valid, // entry offered
	output logic in_ready, // room for an entry
	input wire logic [WIDTH-1:0] in_data, // entry in
	output logic out_valid, // entry waiting
	input wire logic out_ready, // consumer takes entry
	output logic [WIDTH-1:0] out_data // oldest entry
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
	localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

	logic [WIDTH-1:0] store_ff [0:DEPTH-1];
	logic [PW-1:0] wr_ptr_ff;
	logic [PW-1:0] rd_ptr_ff;
	logic [CW-1:0] count_ff;

	wire do_push = in_valid && in_ready;
	wire do_pop = out_valid && out_ready;
	wire [PW-1:0] nxt_wr_ptr = (wr_ptr_ff == PTR_LAST) ? '0 : PW'(wr_ptr_ff + 1'b1);
	wire [PW-1:0] nxt_rd_ptr = (rd_ptr_ff == PTR_LAST) ? '0 : PW'(rd_ptr_ff + 1'b1);

	assign in_ready = (count_ff != CNT_FULL);
	assign out_valid = (count_ff != '0);
	assign out_data = store_ff[rd_ptr_ff];

	always_ff @(posedge clock) begin
		if (do_push)
			store_ff[wr_ptr_ff] <= in_data;
	end

	always_ff @(posedge clock) begin
		if (!resetn) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff <= '0;
		end else begin
			if (do_push)
				wr_ptr_ff <= nxt_wr_ptr;
			if (do_pop)
				rd_ptr_ff <= nxt_rd_ptr;
			if (do_push && !do_pop)
				count_ff <= CW'(count_ff + 1'b1);
			else if (do_pop && !do_push)
				count_ff <= CW'(count_ff - 1'b1);
		end
	end
endmodule

////////////////////////////////////////////////////////////////////////////////

// Function
// - parallel_select high picks the parallel bus, low picks serial input.
// - bus_style_select high: enable plus read/write level; low: separate low strobes.
// - data_command_select with direction decodes data read/write, status read, command write.
// - serial bits sampled on serial clock rise, msb first; byte formed on eighth.
// - data_command_select sampled on each eighth serial clock rise: data or command.
// - serial mode is write-only; data lines never driven.
// - transfers accepted only with chip_select_low low and chip_select_high high.
// - deselected: float data, ignore strobes; serial shifter and counter cleared.
// - display write is queued, then goes into the bus holder and ram in the same cycle, before next write.
// - data read returns holder, then holder loads ram at current address.
// - busy shows on status bit 7; nothing but status read accepted meanwhile.
// - ram is 65 rows by 132 columns: eight pages plus one row.
// - page address changes only by the page set command, never automatically.
// - page 8 is the indicator row; only bit 0 stored and used.
// - column advances by one after each data access, stopping at 83h.
// - segment direction choice mirrors column to segment mapping, ram untouched.
// - start line picks ram row shown first; 65 lines follow from it.
// - reverse, on/off and all-on act on latch output only, not ram.
// - oscillator runs only in master with internal source; else pin clock.
// - refresh latches ram rows on display clock, independent of host accesses.
// - separate strobe style captures the data bus at write strobe rise.
module lcd_host_port (
	input wire logic clock, // system clock, 125 mhz
	input wire logic resetn, // synchronous reset, active low
	input wire logic parallel_select, // high parallel, low serial
	input wire logic bus_style_select, // high enable style, low strobe style
	input wire logic chip_select_low, // chip select, active low
	input wire logic chip_select_high, // chip select, active high
	input wire logic data_command_select, // high data, low command
	input wire logic read_strobe, // read strobe low, or enable clock
	input wire logic write_strobe, // write strobe low, or read/write level
	input wire logic [7:0] data_in, // data bus in; bit 7 serial data, bit 6 serial clock
	output logic [7:0] data_out, // data bus out
	output logic data_oe, // high while the data bus is driven
	input wire logic master_select, // high master
	input wire logic clock_source_select, // high internal oscillator
	input wire logic display_clock_pin, // external display clock
	output logic busy, // command path cannot accept
	output logic display_tick, // one-cycle display clock pulse
	output logic [6:0] scan_line, // common line being driven
	output logic [6:0] display_row, // ram row latched for the line before scan_line stepped
	output logic [131:0] seg_out // segment levels after display modes
);
	function automatic logic [10:0] ram_index(input logic [3:0] pg, input logic [7:0] cl);
		ram_index = 11'(pg) * lcd_port_pkg::COLS_IDX + 11'(cl);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// host pin sampling and access decode

	logic prev_rd_ff;
	logic prev_wr_ff;
	logic prev_sclk_ff;
	logic armed_ff;
	logic read_active_ff;
	logic [7:0] data_out_ff;
	logic [7:0] shift_ff;
	logic [2:0] bitcnt_ff;
	logic [7:0] holder_ff;
	logic [3:0] page_ff;
	logic [7:0] col_ff;
	logic [5:0] start_ff;
	logic disp_on_ff;
	logic seg_rev_ff;
	logic reverse_ff;
	logic all_on_ff;
	logic [lcd_port_pkg::WAIT_W-1:0] wait_ff;

	wire selected = !chip_select_low && chip_select_high;
	wire par_act = armed_ff && selected && parallel_select;
	wire ser_act = armed_ff && selected && !parallel_select;

	// strobe style: read while low, write taken on write strobe rise
	wire sep_rd_start = !bus_style_select && prev_rd_ff && !read_strobe;
	wire sep_rd_end = !bus_style_select && !prev_rd_ff && read_strobe;
	wire sep_wr_done = !bus_style_select && !prev_wr_ff && write_strobe;
	// enable style: direction level qualifies the enable pulse
	wire e_rise = bus_style_select && !prev_rd_ff && read_strobe;
	wire e_fall = bus_style_select && prev_rd_ff && !read_strobe;

	wire rd_start = par_act && (sep_rd_start || (e_rise && write_strobe));
	wire rd_end = par_act && (sep_rd_end || (e_fall && write_strobe));
	wire wr_done = par_act && (sep_wr_done || (e_fall && !write_strobe));

	// serial shifter, msb first
	wire ser_rise = ser_act && !prev_sclk_ff && data_in[6];
	wire ser_done = ser_rise && (bitcnt_ff == lcd_port_pkg::BIT_LAST);
	wire [7:0] ser_byte = {shift_ff[6:0], data_in[7]};

	////////////////////////////////////////////////////////////////////////////////
	// fifo between the host pins and the ram/command processor

	wire fifo_in_ready;
	wire fifo_out_valid;
	wire [lcd_port_pkg::ENTRY_W-1:0] fifo_out_data;
	wire push_rdata = rd_end && data_command_select;
	wire push_valid = wr_done || push_rdata || ser_done;
	wire [1:0] push_op = push_rdata ? lcd_port_pkg::OP_RDATA :
		(data_command_select ? lcd_port_pkg::OP_WDATA : lcd_port_pkg::OP_CMD);
	wire [7:0] push_byte = ser_done ? ser_byte : data_in;
	wire pop = fifo_out_valid && (wait_ff == '0);

	cmd_fifo #(
		.WIDTH(lcd_port_pkg::ENTRY_W),
		.DEPTH(lcd_port_pkg::FIFO_DEPTH)
	) u_fifo (
		.clock(clock),
		.resetn(resetn),
		.in_valid(push_valid),
		.in_ready(fifo_in_ready),
		.in_data({push_op, push_byte}),
		.out_valid(fifo_out_valid),
		.out_ready(pop),
		.out_data(fifo_out_data)
	);

	// full fifo refuses everything but status reads
	assign busy = !fifo_in_ready;
	wire [7:0] status_byte = {!fifo_in_ready, seg_rev_ff, !disp_on_ff, 5'h00};

	////////////////////////////////////////////////////////////////////////////////
	// host read path

	assign data_out = data_out_ff;
	assign data_oe = read_active_ff && par_act;

	always_ff @(posedge clock) begin
		if (!resetn) begin
			prev_rd_ff <= 1'b0;
			prev_wr_ff <= 1'b0;
			prev_sclk_ff <= 1'b0;
			armed_ff <= 1'b0;
		end else begin
			prev_rd_ff <= read_strobe;
			prev_wr_ff <= write_strobe;
			prev_sclk_ff <= data_in[6];
			armed_ff <= 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (!resetn) begin
			read_active_ff <= 1'b0;
			data_out_ff <= 8'h00;
		end else begin
			if (rd_start)
				data_out_ff <= data_command_select ? holder_ff : status_byte;
			if (rd_start)
				read_active_ff <= 1'b1;
			else if (rd_end || !par_act)
				read_active_ff <= 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (!resetn || !ser_act) begin
			shift_ff <= 8'h00;
			bitcnt_ff <= 3'h0;
		end else if (ser_rise) begin
			shift_ff <= ser_byte;
			bitcnt_ff <= 3'(bitcnt_ff + 1'b1);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// processor: commits writes, advances reads, applies commands

	wire [1:0] op = fifo_out_data[9:8];
	wire [7:0] op_byte = fifo_out_data[7:0];
	wire is_wr = pop && (op == lcd_port_pkg::OP_WDATA);
	wire is_rd = pop && (op == lcd_port_pkg::OP_RDATA);
	wire is_cmd = pop && (op == lcd_port_pkg::OP_CMD);

	logic [7:0] mem_ff [0:lcd_port_pkg::BYTES-1];
	wire [10:0] host_idx = ram_index(page_ff, col_ff);
	wire [7:0] ram_rd = mem_ff[host_idx];
	wire ind_page = (page_ff == lcd_port_pkg::IND_PAGE);
	wire [7:0] wr_byte = ind_page ? (op_byte & lcd_port_pkg::IND_MASK) : op_byte;
	wire col_step = (is_wr || is_rd) && (col_ff != lcd_port_pkg::COL_LAST);

	wire cmd_mode = is_cmd && (op_byte[7:4] == lcd_port_pkg::CMD_MODE);
	wire cmd_page = is_cmd && (op_byte[7:4] == lcd_port_pkg::CMD_PAGE)
		&& (op_byte[3:0] <= lcd_port_pkg::IND_PAGE);
	wire cmd_col_hi = is_cmd && (op_byte[7:4] == lcd_port_pkg::CMD_COL_HI);
	wire cmd_col_lo = is_cmd && (op_byte[7:4] == lcd_port_pkg::CMD_COL_LO);
	wire cmd_start = is_cmd && (op_byte[7:6] == lcd_port_pkg::CMD_START_TAG);

	// ram has no reset: contents are undefined until written
	always_ff @(posedge clock) begin
		if (is_wr)
			mem_ff[host_idx] <= wr_byte;
	end

	always_ff @(posedge clock) begin
		if (!resetn) begin
			holder_ff <= 8'h00;
		end else if (pop) begin
			case (op)
				lcd_port_pkg::OP_WDATA: holder_ff <= wr_byte;
				lcd_port_pkg::OP_RDATA: holder_ff <= ram_rd;
				default: holder_ff <= holder_ff;
			endcase
		end
	end

	// each entry holds the processor for a minimum processing time
	always_ff @(posedge clock) begin
		if (!resetn)
			wait_ff <= '0;
		else if (pop)
			wait_ff <= lcd_port_pkg::WAIT_W'(lcd_port_pkg::PROC_CYCLES - 1);
		else if (wait_ff != '0)
			wait_ff <= lcd_port_pkg::WAIT_W'(wait_ff - 1'b1);
	end

	always_ff @(posedge clock) begin
		if (!resetn) begin
			page_ff <= 4'h0;
			col_ff <= 8'h00;
			start_ff <= 6'h00;
		end else begin
			if (cmd_page)
				page_ff <= op_byte[3:0];
			if (cmd_col_hi)
				col_ff[7:4] <= op_byte[3:0];
			else if (cmd_col_lo)
				col_ff[3:0] <= op_byte[3:0];
			else if (col_step)
				col_ff <= 8'(col_ff + 1'b1);
			if (cmd_start)
				start_ff <= op_byte[5:0];
		end
	end

	always_ff @(posedge clock) begin
		if (!resetn) begin
			disp_on_ff <= 1'b0;
			seg_rev_ff <= 1'b0;
			reverse_ff <= 1'b0;
			all_on_ff <= 1'b0;
		end else if (cmd_mode) begin
			disp_on_ff <= op_byte[lcd_port_pkg::MODE_ON_BIT];
			seg_rev_ff <= op_byte[lcd_port_pkg::MODE_SEGREV_BIT];
			reverse_ff <= op_byte[lcd_port_pkg::MODE_REV_BIT];
			all_on_ff <= op_byte[lcd_port_pkg::MODE_ALL_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// display clock and refresh

	logic [lcd_port_pkg::OSC_W-1:0] osc_cnt_ff;
	logic prev_cl_ff;
	logic [6:0] line_ff;
	logic [6:0] row_ff;
	logic [131:0] latch_ff;
	logic [131:0] seg_ff;

	wire osc_run = master_select && clock_source_select;
	wire osc_wrap = (osc_cnt_ff == lcd_port_pkg::OSC_W'(lcd_port_pkg::OSC_CYCLES - 1));
	wire osc_tick = osc_run && osc_wrap;
	wire pin_tick = !osc_run && !prev_cl_ff && display_clock_pin;
	wire disp_tick = osc_tick || pin_tick;
	wire [6:0] row_sum = 7'(start_ff) + line_ff;
	wire [6:0] row_now = (row_sum >= lcd_port_pkg::ROW_COUNT) ?
		7'(row_sum - lcd_port_pkg::ROW_COUNT) : row_sum;
	wire [3:0] row_page = row_now[6:3];
	wire [2:0] row_bit = row_now[2:0];

	assign display_tick = disp_tick;
	assign scan_line = line_ff;
	assign display_row = row_ff;
	assign seg_out = seg_ff;

	always_ff @(posedge clock) begin
		if (!resetn || !osc_run || osc_wrap)
			osc_cnt_ff <= '0;
		else
			osc_cnt_ff <= lcd_port_pkg::OSC_W'(osc_cnt_ff + 1'b1);
	end

	always_ff @(posedge clock) begin
		if (!resetn) begin
			prev_cl_ff <= 1'b0;
			line_ff <= 7'h00;
			row_ff <= 7'h00;
		end else begin
			prev_cl_ff <= display_clock_pin;
			if (disp_tick) begin
				line_ff <= (line_ff == lcd_port_pkg::LINE_LAST) ? 7'h00 : 7'(line_ff + 1'b1);
				row_ff <= row_now;
			end
		end
	end

	// the refresh port reads ram on its own, so host traffic never disturbs it
	generate
		for (genvar c = 0; c < lcd_port_pkg::COLS; c++) begin : g_col
			wire mirror_bit = seg_rev_ff ? latch_ff[lcd_port_pkg::COLS - 1 - c] : latch_ff[c];
			wire seg_nxt = disp_on_ff && (all_on_ff || (mirror_bit ^ reverse_ff));
			always_ff @(posedge clock) begin
				if (!resetn) begin
					latch_ff[c] <= 1'b0;
					seg_ff[c] <= 1'b0;
				end else begin
					if (disp_tick)
						latch_ff[c] <= mem_ff[ram_index(row_page, 8'(c))][row_bit];
					seg_ff[c] <= seg_nxt;
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// checks

	// looks at the read flag itself, so a stuck flag is caught as well as a live bus
	property p_float_deselect;
		@(posedge clock) disable iff (!resetn)
		!selected |=> !read_active_ff && !data_oe;
	endproperty
	a_float_deselect: assert property (p_float_deselect) else $error("bus driven while deselected");

	property p_serial_no_drive;
		@(posedge clock) disable iff (!resetn)
		!parallel_select |=> !read_active_ff && !data_oe;
	endproperty
	a_serial_no_drive: assert property (p_serial_no_drive) else $error("bus driven in serial mode");

	// the fifo may drain while deselected, never fill
	property p_push_selected;
		@(posedge clock) disable iff (!resetn)
		!selected |=> u_fifo.count_ff <= $past(u_fifo.count_ff);
	endproperty
	a_push_selected: assert property (p_push_selected) else $error("transfer while deselected");

	property p_serial_byte;
		@(posedge clock) disable iff (!resetn)
		ser_rise && (bitcnt_ff == lcd_port_pkg::BIT_LAST) && fifo_in_ready
		|=> u_fifo.count_ff != '0;
	endproperty
	a_serial_byte: assert property (p_serial_byte) else $error("eighth serial edge lost");

	property p_busy_full;
		@(posedge clock) disable iff (!resetn)
		(u_fifo.count_ff == 3'(lcd_port_pkg::FIFO_DEPTH)) |-> busy && status_byte[7];
	endproperty
	a_busy_full: assert property (p_busy_full) else $error("busy not shown when full");

	property p_col_stop;
		@(posedge clock) disable iff (!resetn)
		(is_wr || is_rd) && (col_ff == lcd_port_pkg::COL_LAST) && !is_cmd
		|=> col_ff == lcd_port_pkg::COL_LAST;
	endproperty
	a_col_stop: assert property (p_col_stop) else $error("column moved past 83h");

	property p_col_step;
		@(posedge clock) disable iff (!resetn)
		(is_wr || is_rd) && (col_ff != lcd_port_pkg::COL_LAST)
		|=> col_ff == 8'($past(col_ff) + 1'b1);
	endproperty
	a_col_step: assert property (p_col_step) else $error("column did not advance");

	property p_page_hold;
		@(posedge clock) disable iff (!resetn)
		!cmd_page |=> $stable(page_ff);
	endproperty
	a_page_hold: assert property (p_page_hold) else $error("page changed without command");

	property p_indicator;
		@(posedge clock) disable iff (!resetn)
		is_wr && ind_page |=> holder_ff[7:1] == 7'h00;
	endproperty
	a_indicator: assert property (p_indicator) else $error("indicator page kept upper bits");

	property p_holder_read;
		@(posedge clock) disable iff (!resetn)
		is_rd |=> holder_ff == $past(ram_rd);
	endproperty
	a_holder_read: assert property (p_holder_read) else $error("holder not loaded from ram");

	property p_row_range;
		@(posedge clock) disable iff (!resetn)
		disp_tick |=> (row_ff < lcd_port_pkg::ROW_COUNT) && (line_ff <= lcd_port_pkg::LINE_LAST);
	endproperty
	a_row_range: assert property (p_row_range) else $error("display row out of range");

	property p_osc_gate;
		@(posedge clock) disable iff (!resetn)
		!osc_run |=> osc_cnt_ff == '0;
	endproperty
	a_osc_gate: assert property (p_osc_gate) else $error("oscillator ran while disabled");
endmodule

// ### lcd_host_model.sv
// host processor model driving the lcd port pins
`timescale 1ns/1ns

module lcd_host_model (
	input wire logic clock, // system clock
	input wire logic [7:0] data_out, // device read data
	input wire logic data_oe, // device drives the bus
	output logic parallel_select, // bus kind strap
	output logic bus_style_select, // strobe style strap
	output logic chip_select_low, // select, active low
	output logic chip_select_high, // select, active high
	output logic data_command_select, // data or command
	output logic read_strobe, // read strobe or enable
	output logic write_strobe, // write strobe or direction
	output logic [7:0] data_in // resolved bus level
);
	logic [7:0] drv = 8'h00;
	logic drv_on = 1'b0;
	logic [7:0] last = 8'h00;

	// a released bus toggles, so a stale value can never pass for read data
	assign data_in = drv_on ? drv : (data_oe ? data_out : ~last);

	always @(posedge clock) begin
		last <= data_in;
	end

	initial begin
		parallel_select = 1'b1;
		bus_style_select = 1'b0;
		chip_select_low = 1'b1;
		chip_select_high = 1'b0;
		data_command_select = 1'b0;
		read_strobe = 1'b1;
		write_strobe = 1'b1;
	end

////////////////////////////////////////////////////////////////////////////////

	task automatic sel(input logic on);
		@(posedge clock);
		chip_select_low <= !on;
		chip_select_high <= on;
		repeat (3) @(posedge clock);
	endtask

	// straps change only while deselected
	task automatic mode(input logic ps, input logic st);
		sel(1'b0);
		parallel_select <= ps;
		bus_style_select <= st;
		read_strobe <= !st;
		write_strobe <= 1'b1;
		drv_on <= !ps;
		drv <= 8'h00;
		sel(1'b1);
	endtask

	// trailing idle keeps the minimum cycle time, so busy is never polled
	task automatic pwrite(input logic dc, input logic [7:0] v);
		@(posedge clock);
		data_command_select <= dc;
		drv <= v;
		drv_on <= 1'b1;
		if (bus_style_select) write_strobe <= 1'b0;
		repeat (2) @(posedge clock);
		if (bus_style_select) read_strobe <= 1'b1;
		else write_strobe <= 1'b0;
		repeat (2) @(posedge clock);
		if (bus_style_select) read_strobe <= 1'b0;
		else write_strobe <= 1'b1;
		repeat (2) @(posedge clock);
		write_strobe <= 1'b1;
		drv_on <= 1'b0;
		repeat (5) @(posedge clock);
	endtask

	task automatic pread(input logic dc, output logic [7:0] v, output logic oe);
		@(posedge clock);
		data_command_select <= dc;
		repeat (2) @(posedge clock);
		read_strobe <= bus_style_select;
		repeat (4) @(posedge clock);
		v = data_out;
		oe = data_oe;
		read_strobe <= !bus_style_select;
		repeat (6) @(posedge clock);
	endtask

	// serial clock rests low between bytes
	task automatic sbyte(input logic dc, input logic [7:0] v, input int n);
		for (int i = 7; i > 7 - n; i--) begin
			@(posedge clock);
			data_command_select <= dc;
			drv[7] <= v[i];
			drv[6] <= 1'b0;
			repeat (2) @(posedge clock);
			drv[6] <= 1'b1;
			repeat (2) @(posedge clock);
		end
		@(posedge clock);
		drv[6] <= 1'b0;
		repeat (5) @(posedge clock);
	endtask
endmodule

// ### lcd_host_port_test.sv
// self-checking bench for the lcd host port
`timescale 1ns/1ns

module lcd_host_port_test;
	logic clock = 1'b0;
	logic resetn = 1'b0;
	logic master_select = 1'b0;
	logic clock_source_select = 1'b0;
	logic display_clock_pin = 1'b0;
	logic parallel_select, bus_style_select, chip_select_low, chip_select_high;
	logic data_command_select, read_strobe, write_strobe, data_oe, busy, display_tick;
	logic [7:0] data_in, data_out;
	logic [6:0] scan_line, display_row;
	logic [131:0] seg_out;
	int error_cnt = 0;
	int num_checks = 0;

	always #4 clock = ~clock;

	lcd_host_port dut (.clock(clock), .resetn(resetn), .parallel_select(parallel_select),
		.bus_style_select(bus_style_select), .chip_select_low(chip_select_low),
		.chip_select_high(chip_select_high), .data_command_select(data_command_select),
		.read_strobe(read_strobe), .write_strobe(write_strobe), .data_in(data_in),
		.data_out(data_out), .data_oe(data_oe), .master_select(master_select),
		.clock_source_select(clock_source_select), .display_clock_pin(display_clock_pin),
		.busy(busy), .display_tick(display_tick), .scan_line(scan_line),
		.display_row(display_row), .seg_out(seg_out));

	lcd_host_model host (.clock(clock), .data_out(data_out), .data_oe(data_oe),
		.parallel_select(parallel_select), .bus_style_select(bus_style_select),
		.chip_select_low(chip_select_low), .chip_select_high(chip_select_high),
		.data_command_select(data_command_select), .read_strobe(read_strobe),
		.write_strobe(write_strobe), .data_in(data_in));

////////////////////////////////////////////////////////////////////////////////

	task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chk_bit(input string what, input logic exp, input logic got);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("FAIL %s expected %b seen %b", what, exp, got);
		end
	endtask

	task automatic give_verdict;
		if (error_cnt == 0 && num_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic cmd(input logic [7:0] b);
		host.pwrite(1'b0, b);
	endtask

	task automatic col(input logic [7:0] c);
		cmd({4'h2, c[7:4]});
		cmd({4'h3, c[3:0]});
	endtask

	task automatic rd(input logic dc, input logic [7:0] exp);
		logic [7:0] v;
		logic oe;
		host.pread(dc, v, oe);
		chk_byte("read_data", exp, v);
		chk_bit("read_oe", 1'b1, oe);
	endtask

	// address set followed by the discarded read
	task automatic seek(input logic [7:0] c);
		logic [7:0] v;
		logic oe;
		col(c);
		host.pread(1'b1, v, oe);
	endtask

	task automatic tick;
		@(posedge clock);
		display_clock_pin <= 1'b1;
		@(negedge clock);
		chk_bit("tick_pulse", 1'b1, display_tick);
		repeat (2) @(posedge clock);
		display_clock_pin <= 1'b0;
		repeat (4) @(posedge clock);
	endtask

	initial begin
		logic [7:0] v;
		logic oe;
		logic [6:0] s0;
		repeat (3) @(posedge clock);
		resetn <= 1'b1;
		repeat (3) @(posedge clock);
		chk_bit("busy", 1'b0, busy);
		chk_bit("oe_idle", 1'b0, data_oe);
		chk_bit("seg_clear", 1'b1, seg_out === '0);
		host.mode(1'b1, 1'b0);
		cmd(8'h01);
		cmd(8'h10);
		col(8'h00);
		host.pwrite(1'b1, 8'ha5);
		host.pwrite(1'b1, 8'h3c);
		// every read-ahead must land on a written byte: ram powers up unknown
		host.pwrite(1'b1, 8'h7e);
		seek(8'h00);
		rd(1'b1, 8'ha5);
		rd(1'b1, 8'h3c);
		rd(1'b0, 8'h00);
		cmd(8'h02);
		rd(1'b0, 8'h60);
		cmd(8'h01);
		col(8'h83);
		host.pwrite(1'b1, 8'h11);
		host.pwrite(1'b1, 8'h22);
		seek(8'h83);
		rd(1'b1, 8'h22);
		rd(1'b1, 8'h22);
		cmd(8'h18);
		col(8'h05);
		host.pwrite(1'b1, 8'hff);
		host.pwrite(1'b1, 8'hfe);
		seek(8'h05);
		rd(1'b1, 8'h01);
		cmd(8'h10);
		col(8'h00);
		host.sel(1'b0);
		host.pwrite(1'b1, 8'h99);
		host.pread(1'b1, v, oe);
		chk_bit("oe_deselect", 1'b0, oe);
		host.sel(1'b1);
		seek(8'h00);
		rd(1'b1, 8'ha5);
		host.mode(1'b1, 1'b1);
		col(8'h01);
		host.pwrite(1'b1, 8'h5a);
		seek(8'h01);
		rd(1'b1, 8'h5a);
		host.mode(1'b0, 1'b0);
		host.sbyte(1'b1, 8'hff, 3);
		host.sel(1'b0);
		host.sel(1'b1);
		host.sbyte(1'b0, 8'h28, 8);
		host.sbyte(1'b0, 8'h32, 8);
		host.sbyte(1'b1, 8'hc3, 8);
		chk_bit("oe_serial", 1'b0, data_oe);
		host.mode(1'b1, 1'b0);
		seek(8'h82);
		rd(1'b1, 8'hc3);
		cmd(8'h40);
		// the latch stays clear until a first display clock arrives
		tick();
		for (int i = 0; i < 70 && display_row !== 7'h00; i++) begin
			tick();
		end
		chk_byte("row_zero", 8'h00, {1'b0, display_row});
		chk_bit("seg_first", 1'b1, seg_out[0]);
		chk_bit("seg_last", 1'b0, seg_out[131]);
		cmd(8'h03);
		chk_bit("seg_first_rev", 1'b0, seg_out[0]);
		chk_bit("seg_last_rev", 1'b1, seg_out[131]);
		cmd(8'h05);
		chk_bit("seg_inverse", 1'b0, seg_out[0]);
		cmd(8'h09);
		chk_bit("seg_all_on", 1'b1, seg_out === '1);
		cmd(8'h00);
		chk_bit("seg_off", 1'b1, seg_out === '0);
		cmd(8'h01);
		seek(8'h00);
		rd(1'b1, 8'ha5);
		cmd(8'h7c);
		for (int i = 0; i < 8; i++) begin
			tick();
			// row latched at a tick belongs to the line before the counter stepped
			chk_byte("row_scroll", 8'((60 + scan_line + 64) % 65), {1'b0, display_row});
		end
		master_select <= 1'b1;
		clock_source_select <= 1'b1;
		@(negedge clock);
		s0 = scan_line;
		repeat (600) @(negedge clock);
		chk_bit("osc_run", 1'b1, scan_line !== s0);
		@(posedge clock);
		clock_source_select <= 1'b0;
		repeat (3) @(negedge clock);
		s0 = scan_line;
		repeat (600) @(negedge clock);
		chk_bit("osc_stop", 1'b1, scan_line === s0);
		give_verdict();
	end

	// whole sequence needs well under 8000 cycles
	initial begin
		repeat (20000) @(posedge clock);
		error_cnt++;
		give_verdict();
	end
endmodule
